// ===== csi2_pattern_gen.sv
// csi-2 test pattern generator with indirect register page
// assumes it shares clk_sys with the csi-2 transmitter, which adds ecc and crc
`timescale 1ns/1ps
`default_nettype none
// How it works
// - colour bar or fixed pattern, selectable
// - first bars carry AA, 33, F0, 7F
// - last bar stretches to fill the line
// - one, two, four or eight bars
// - line and bar byte lengths programmable
// - line headers carry programmed datatype and channel
// - active and total lines per frame programmable
// - line period count sets line starts
// - front porch blank lines before frame end
// - back porch blank lines after frame start
// - runs on transmitter clock, no crossing
// - output is csi-2 packets, not raw bytes
// - fixed mode shares all frame geometry
// - fixed bars alternate data and inverse
// - fixed block up to sixteen bytes, cyclic
// - sixteen byte registers hold the block
// - configuration lives on indirect page zero
// - page, offset, data at B0, B1, B2
// - line period counted in link units
module csi2_pattern_gen #(
  parameter int UNIT_CYCLES = pattern_gen_pkg::LINE_UNIT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  output pattern_gen_pkg::csi_beat_t txBeat,
  output logic txValid,
  input wire logic txReady,
  output logic frameActive
);

  // ****************************************
  // indirect register access
  // ****************************************
  logic [7:0] page;
  logic [7:0] offset;
  logic [15:0][7:0] cfgByte;
  logic [7:0] blockLenReg;
  logic [15:0][7:0] patternBytes;
  pattern_gen_pkg::gen_state_t state;
  pattern_gen_pkg::gen_state_t next_state;

  wire dataAccess = regAddr == pattern_gen_pkg::ADDR_DATA && page == pattern_gen_pkg::PAGE_PATGEN;
  wire cfgWrite = regWrite && dataAccess && offset < pattern_gen_pkg::OFS_CFG_END;
  wire blkWrite = regWrite && dataAccess && offset == pattern_gen_pkg::OFS_BLOCK_LEN;
  wire patWrite = regWrite && dataAccess && offset[7:4] == pattern_gen_pkg::OFS_PATTERN_BASE[7:4];

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      page <= 8'h00;
      offset <= 8'h00;
    end else begin
      if (regWrite && regAddr == pattern_gen_pkg::ADDR_PAGE) page <= regWdata;
      if (regWrite && regAddr == pattern_gen_pkg::ADDR_OFFSET) offset <= regWdata;
    end
  end

  for (genvar i = 0; i < 16; i++) begin : g_cfg
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        cfgByte[i] <= pattern_gen_pkg::RST_CFG_BYTES[i*8 +: 8];
      end else if (cfgWrite && offset[3:0] == 4'(i)) begin
        cfgByte[i] <= regWdata;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) blockLenReg <= pattern_gen_pkg::RST_BLOCK_LEN;
    else if (blkWrite) blockLenReg <= regWdata;
  end

  pattern_byte_store #(.DEPTH(16)) u_store (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wrEn(patWrite),
    .wrIndex(offset[3:0]),
    .wrData(regWdata),
    .bytes(patternBytes)
  );

  // status shows frame activity and the sequencer state
  wire [7:0] statusByte = {4'h0, frameActive, state};
  wire [7:0] pageValue = (offset < pattern_gen_pkg::OFS_CFG_END) ? cfgByte[offset[3:0]] :
                         (offset == pattern_gen_pkg::OFS_BLOCK_LEN) ? blockLenReg :
                         (offset == pattern_gen_pkg::OFS_STATUS) ? statusByte :
                         (offset[7:4] == pattern_gen_pkg::OFS_PATTERN_BASE[7:4]) ? patternBytes[offset[3:0]] :
                         8'h00;
  wire [7:0] readValue = (regAddr == pattern_gen_pkg::ADDR_PAGE) ? page :
                         (regAddr == pattern_gen_pkg::ADDR_OFFSET) ? offset :
                         dataAccess ? pageValue : 8'h00;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) regRdata <= 8'h00;
    else if (regRead) regRdata <= readValue;
  end

  // ****************************************
  // configuration fields
  // ****************************************
  wire enable = cfgByte[pattern_gen_pkg::OFS_CTL][pattern_gen_pkg::CTL_ENABLE_BIT];
  wire fixedMode = cfgByte[pattern_gen_pkg::OFS_CFG][pattern_gen_pkg::CFG_FIXED_BIT];
  wire [1:0] barsCode = cfgByte[pattern_gen_pkg::OFS_CFG][pattern_gen_pkg::CFG_BARS_LSB +: 2];
  wire [2:0] lastBar = 3'((4'd1 << barsCode) - 4'd1);
  wire [7:0] dataId = cfgByte[pattern_gen_pkg::OFS_CSI_ID];
  wire [15:0] lineSize = {cfgByte[pattern_gen_pkg::OFS_LINE_SIZE_HI], cfgByte[pattern_gen_pkg::OFS_LINE_SIZE_LO]};
  wire [15:0] barSize = {cfgByte[pattern_gen_pkg::OFS_BAR_SIZE_HI], cfgByte[pattern_gen_pkg::OFS_BAR_SIZE_LO]};
  wire [15:0] actLines = {cfgByte[pattern_gen_pkg::OFS_ACT_LINES_HI], cfgByte[pattern_gen_pkg::OFS_ACT_LINES_LO]};
  wire [15:0] totLines = {cfgByte[pattern_gen_pkg::OFS_TOT_LINES_HI], cfgByte[pattern_gen_pkg::OFS_TOT_LINES_LO]};
  wire [15:0] linePeriodCount = {cfgByte[pattern_gen_pkg::OFS_LINE_PD_HI], cfgByte[pattern_gen_pkg::OFS_LINE_PD_LO]};
  wire [7:0] vbp = cfgByte[pattern_gen_pkg::OFS_VBP];
  wire [7:0] vfp = cfgByte[pattern_gen_pkg::OFS_VFP];
  // zero or oversized lengths fall back to the full sixteen bytes
  wire [3:0] blockLenM1 = (blockLenReg == 8'h00 || blockLenReg > 8'h10) ? 4'hF : 4'(blockLenReg - 8'h01);

  // ****************************************
  // line timing and frame sequencing
  // ****************************************
  logic [15:0] lineSlot;
  logic [15:0] lineTimer;
  logic [15:0] unitCnt;
  logic [15:0] byteCnt;
  logic [15:0] barByteCnt;
  logic [2:0] barIdx;
  logic [3:0] blkIdx;
  pattern_gen_pkg::csi_beat_t next_beat;

  wire advance = !txValid || txReady;
  wire unitTick = unitCnt == 16'(UNIT_CYCLES - 1);
  // the final unit tick ends the slot, so a slot lasts exactly count units
  wire lineDone = state == pattern_gen_pkg::ST_WAIT &&
                  (lineTimer == 16'h0000 || (lineTimer == 16'h0001 && unitTick));
  wire [16:0] activeEnd = 17'(vbp) + 17'(actLines);
  wire [16:0] feSlot = activeEnd + 17'(vfp);
  wire frameWrap = lineDone && (17'(lineSlot) + 17'h00001 >= 17'(totLines));
  wire frameStart = state == pattern_gen_pkg::ST_IDLE && enable;
  wire slotStart = frameStart || (lineDone && !(frameWrap && !enable));
  wire [15:0] targetSlot = (state == pattern_gen_pkg::ST_IDLE || frameWrap) ? 16'h0000 : lineSlot + 16'h0001;
  wire lineEnd = byteCnt == lineSize - 16'h0001;
  wire emit = advance && state inside {pattern_gen_pkg::ST_FS, pattern_gen_pkg::ST_FE,
                                       pattern_gen_pkg::ST_HDR, pattern_gen_pkg::ST_DATA};

  // what a slot carries: frame end, an active line, or blanking
  function automatic pattern_gen_pkg::gen_state_t slotWork(input logic [15:0] slot);
    pattern_gen_pkg::gen_state_t work;
    work = pattern_gen_pkg::ST_WAIT;
    if (17'(slot) == feSlot) work = pattern_gen_pkg::ST_FE;
    else if (slot >= 16'(vbp) && 17'(slot) < activeEnd) work = pattern_gen_pkg::ST_HDR;
    return work;
  endfunction : slotWork

  always_comb begin
    next_state = state;
    case (state)
      pattern_gen_pkg::ST_IDLE: if (enable) next_state = pattern_gen_pkg::ST_FS;
      pattern_gen_pkg::ST_WAIT: begin
        if (lineDone && frameWrap) next_state = enable ? pattern_gen_pkg::ST_FS : pattern_gen_pkg::ST_IDLE;
        else if (lineDone) next_state = slotWork(targetSlot);
      end
      pattern_gen_pkg::ST_FS: if (advance) next_state = slotWork(lineSlot);
      pattern_gen_pkg::ST_FE: if (advance) next_state = pattern_gen_pkg::ST_WAIT;
      pattern_gen_pkg::ST_HDR: begin
        if (advance) next_state = (lineSize == 16'h0000) ? pattern_gen_pkg::ST_WAIT : pattern_gen_pkg::ST_DATA;
      end
      pattern_gen_pkg::ST_DATA: if (advance && lineEnd) next_state = pattern_gen_pkg::ST_WAIT;
      default: next_state = pattern_gen_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) state <= pattern_gen_pkg::ST_IDLE;
    else state <= next_state;
  end

  // a line that overruns its period holds the timer at zero, so lines stretch, never overlap
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lineSlot <= 16'h0000;
      lineTimer <= 16'h0000;
      unitCnt <= 16'h0000;
    end else if (slotStart) begin
      lineSlot <= targetSlot;
      lineTimer <= linePeriodCount;
      unitCnt <= 16'h0000;
    end else begin
      unitCnt <= unitTick ? 16'h0000 : unitCnt + 16'h0001;
      if (unitTick && lineTimer != 16'h0000) lineTimer <= lineTimer - 16'h0001;
    end
  end

  assign frameActive = state != pattern_gen_pkg::ST_IDLE;

  // ****************************************
  // byte generation
  // ****************************************
  wire barEnd = barByteCnt == barSize - 16'h0001 && barIdx != lastBar;
  wire [7:0] refByte = pattern_gen_pkg::REF_BAR_BYTES[{barIdx, 3'b000} +: 8];
  wire [7:0] fixRaw = patternBytes[blkIdx];
  wire [7:0] fixByte = fixRaw ^ {8{barIdx[0]}};
  wire [7:0] pixelByte = fixedMode ? fixByte : refByte;

  // counters are shared by both modes so geometry stays common
  always_ff @(posedge clk_sys) begin
    if (!rst_n || (emit && state == pattern_gen_pkg::ST_HDR)) begin
      byteCnt <= 16'h0000;
      barByteCnt <= 16'h0000;
      barIdx <= 3'h0;
      blkIdx <= 4'h0;
    end else if (emit && state == pattern_gen_pkg::ST_DATA) begin
      byteCnt <= byteCnt + 16'h0001;
      barByteCnt <= barEnd ? 16'h0000 : barByteCnt + 16'h0001;
      if (barEnd) barIdx <= barIdx + 3'h1;
      blkIdx <= (blkIdx == blockLenM1) ? 4'h0 : blkIdx + 4'h1;
    end
  end

  // ****************************************
  // packet beats to the transmitter
  // ****************************************
  always_comb begin
    next_beat = '0;
    case (state)
      pattern_gen_pkg::ST_FS: begin
        next_beat.header = 1'b1;
        next_beat.dataId = {dataId[pattern_gen_pkg::ID_VC_LSB +: 2], pattern_gen_pkg::DT_FRAME_START};
        next_beat.last = 1'b1;
      end
      pattern_gen_pkg::ST_FE: begin
        next_beat.header = 1'b1;
        next_beat.dataId = {dataId[pattern_gen_pkg::ID_VC_LSB +: 2], pattern_gen_pkg::DT_FRAME_END};
        next_beat.last = 1'b1;
      end
      pattern_gen_pkg::ST_HDR: begin
        next_beat.header = 1'b1;
        next_beat.dataId = dataId;
        next_beat.wordCount = lineSize;
        next_beat.last = lineSize == 16'h0000;
      end
      pattern_gen_pkg::ST_DATA: begin
        next_beat.payload = pixelByte;
        next_beat.last = lineEnd;
      end
      default: next_beat = '0;
    endcase
  end

  // same clock as the transmitter: a plain valid/ready register, no crossing
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      txBeat <= '0;
      txValid <= 1'b0;
    end else if (emit) begin
      txBeat <= next_beat;
      txValid <= 1'b1;
    end else if (txReady) begin
      txValid <= 1'b0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_first_bar_aa: assert property (@(posedge clk_sys) disable iff (!rst_n)
    emit && state == pattern_gen_pkg::ST_DATA && !fixedMode && barIdx == 3'h0 |=> txBeat.payload == 8'hAA)
    else $error("first reference bar byte wrong");
  a_fourth_bar_7f: assert property (@(posedge clk_sys) disable iff (!rst_n)
    emit && state == pattern_gen_pkg::ST_DATA && !fixedMode && barIdx == 3'h3 |=> txBeat.payload == 8'h7F)
    else $error("fourth reference bar byte wrong");
  a_last_bar_80: assert property (@(posedge clk_sys) disable iff (!rst_n)
    emit && state == pattern_gen_pkg::ST_DATA && !fixedMode && barIdx == 3'h7 |=> txBeat.payload == 8'h80)
    else $error("final reference bar byte wrong");
  a_bar_count_limit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state == pattern_gen_pkg::ST_DATA |-> barIdx <= lastBar)
    else $error("bar index beyond programmed count");
  a_line_length_end: assert property (@(posedge clk_sys) disable iff (!rst_n)
    emit && state == pattern_gen_pkg::ST_DATA && byteCnt == lineSize - 16'h0001
    |=> txValid && txBeat.last ##0 state == pattern_gen_pkg::ST_WAIT)
    else $error("line did not end at programmed length");
  a_header_ids: assert property (@(posedge clk_sys) disable iff (!rst_n)
    emit && state == pattern_gen_pkg::ST_HDR |=> txBeat.header && txBeat.dataId == $past(dataId)
    && txBeat.wordCount == $past(lineSize))
    else $error("long packet header fields wrong");
  a_fixed_inverse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    emit && state == pattern_gen_pkg::ST_DATA && fixedMode && barIdx[0] |=> txBeat.payload == ~$past(fixRaw))
    else $error("odd fixed bar not inverted");
  a_block_wraps: assert property (@(posedge clk_sys) disable iff (!rst_n)
    emit && state == pattern_gen_pkg::ST_DATA && blkIdx == blockLenM1 && !lineEnd |=> blkIdx == 4'h0)
    else $error("fixed block did not wrap");
  a_idle_stays: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state == pattern_gen_pkg::ST_IDLE && !enable |=> state == pattern_gen_pkg::ST_IDLE && !txValid)
    else $error("frame started while disabled");
  a_tx_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
    txValid && !txReady |=> txValid && $stable(txBeat))
    else $error("beat changed under back-pressure");

  c_frame_end: cover property (@(posedge clk_sys) disable iff (!rst_n) emit && state == pattern_gen_pkg::ST_FE);
  c_fixed_data: cover property (@(posedge clk_sys) disable iff (!rst_n)
    emit && state == pattern_gen_pkg::ST_DATA && fixedMode && barIdx[0]);
  c_frame_wrap: cover property (@(posedge clk_sys) disable iff (!rst_n) frameWrap && enable);

endmodule : csi2_pattern_gen
`default_nettype wire

// ===== csi2_pattern_gen_tb.sv
// self-checking bench for the csi-2 test pattern generator
// assumes csi_tx_sink paces txReady and one clock per line period unit
`timescale 1ns/1ps
`default_nettype none
module csi2_pattern_gen_tb;
  // ****************************************
  // signals
  // ****************************************
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata;
  logic txValid;
  logic txReady;
  logic frameActive;
  logic slow = 1'b0;
  logic stalled = 1'b0;
  logic fixedMode = 1'b0;
  logic [7:0] csiId;
  logic [7:0] got;
  logic [7:0] pat [16];
  logic [7:0] refTab [8] = '{8'hAA, 8'h33, 8'hF0, 8'h7F, 8'h55, 8'hCC, 8'h0F, 8'h80};
  logic [7:0] defOfs [5] = '{8'h01, 8'h02, 8'h03, 8'h10, 8'h11};
  logic [7:0] defVal [5] = '{8'h00, 8'h30, 8'h24, 8'h03, 8'h00};
  pattern_gen_pkg::csi_beat_t txBeat;
  pattern_gen_pkg::csi_beat_t heldBeat;
  pattern_gen_pkg::csi_beat_t expQ [$];
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  int tFs = -1;
  int tLine = -1;
  int fsSeen = 0;
  int bars, barLen, lineLen, blkLen, vbp, vfp, tot;
  int act = 2;
  int period = 64;

  csi2_pattern_gen #(.UNIT_CYCLES(1)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .txBeat(txBeat),
    .txValid(txValid), .txReady(txReady), .frameActive(frameActive));
  csi_tx_sink sink (.clk_sys(clk_sys), .rst_n(rst_n), .slow(slow), .txReady(txReady));

  always #25 clk_sys = ~clk_sys;

  // ****************************************
  // stimulus tasks
  // ****************************************
  task automatic check(input string n, input logic [34:0] e, input logic [34:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, g);
    end
  endtask : check

  task automatic results();
    if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge clk_sys);
    regWrite = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(negedge clk_sys);
    regRead = 1'b1;
    regAddr = a;
    @(negedge clk_sys);
    regRead = 1'b0;
    got = regRdata;
  endtask : rd

  task automatic pg(input logic [7:0] ofs, input logic [7:0] d);
    wr(pattern_gen_pkg::ADDR_OFFSET, ofs);
    wr(pattern_gen_pkg::ADDR_DATA, d);
  endtask : pg

  task automatic rdp(input logic [7:0] ofs);
    wr(pattern_gen_pkg::ADDR_OFFSET, ofs);
    rd(pattern_gen_pkg::ADDR_DATA);
  endtask : rdp

  task automatic pg16(input logic [7:0] hi, input int v);
    pg(hi, 8'(v >> 8));
    pg(8'(hi + 8'h01), 8'(v));
  endtask : pg16

  // ****************************************
  // reference model
  // ****************************************
  // header beats keep a kind in payload: 0 frame start, 1 line, 2 frame end
  task automatic pushFrame();
    pattern_gen_pkg::csi_beat_t b;
    int bar;
    b = '0;
    b.header = 1'b1;
    b.last = 1'b1;
    b.dataId = {csiId[7:6], pattern_gen_pkg::DT_FRAME_START};
    expQ.push_back(b);
    for (int ln = 0; ln < act; ln++) begin
      b = '0;
      b.header = 1'b1;
      b.dataId = csiId;
      b.wordCount = 16'(lineLen);
      b.payload = 8'h01;
      expQ.push_back(b);
      for (int k = 0; k < lineLen; k++) begin
        bar = (k / barLen < bars - 1) ? k / barLen : bars - 1;
        b = '0;
        b.last = (k == lineLen - 1);
        b.payload = fixedMode ? pat[k % blkLen] ^ ((bar % 2) ? 8'hFF : 8'h00) : refTab[bar];
        expQ.push_back(b);
      end
    end
    b = '0;
    b.header = 1'b1;
    b.last = 1'b1;
    b.payload = 8'h02;
    b.dataId = {csiId[7:6], pattern_gen_pkg::DT_FRAME_END};
    expQ.push_back(b);
  endtask : pushFrame

  task automatic take(input pattern_gen_pkg::csi_beat_t b);
    pattern_gen_pkg::csi_beat_t e;
    if (expQ.size() == 0) begin
      check("unexpected beat", 35'h0, 35'h1);
      return;
    end
    e = expQ.pop_front();
    check("header flag", e.header, b.header);
    check("last flag", e.last, b.last);
    if (!e.header) begin
      check("payload", e.payload, b.payload);
      return;
    end
    check("data id", e.dataId, b.dataId);
    check("word count", e.wordCount, b.wordCount);
    if (e.payload == 8'h00) begin
      check("frame active", 1'b1, frameActive);
      if (!slow && tFs >= 0) check("frame span", tot * period, cyc - tFs);
      tFs = cyc;
      tLine = -1;
      fsSeen++;
    end else if (e.payload == 8'h01) begin
      if (!slow) check("line start", tLine < 0 ? vbp * period : period, cyc - (tLine < 0 ? tFs : tLine));
      tLine = cyc;
    end else if (!slow) begin
      check("front porch", (vfp + 1) * period, cyc - tLine);
    end
  endtask : take

  // a stalled beat must come back unchanged on the next edge
  always @(posedge clk_sys) begin
    cyc++;
    if (rst_n && stalled) check("held beat", {1'b1, heldBeat}, {txValid, txBeat});
    stalled = rst_n & txValid & ~txReady;
    heldBeat = txBeat;
    if (rst_n && txValid && txReady) take(txBeat);
  end

  task automatic runCase(input int code, input logic fx, input int nFr, input logic [7:0] blk);
    int n;
    bars = 1 << code;
    fixedMode = fx;
    blkLen = (blk == 0 || blk > 16) ? 16 : blk;
    barLen = 3 * (1 + code % 2);
    lineLen = barLen * bars + 3;
    vbp = 1 + code % 2;
    vfp = code % 2;
    tot = vbp + act + vfp + 1;
    csiId = {2'($urandom_range(3)), 6'($urandom_range(63, 2))};
    pg(pattern_gen_pkg::OFS_CFG, {fx, 1'b0, 2'(code), 4'h0});
    pg(pattern_gen_pkg::OFS_CSI_ID, csiId);
    pg(pattern_gen_pkg::OFS_BLOCK_LEN, blk);
    pg16(pattern_gen_pkg::OFS_LINE_SIZE_HI, lineLen);
    pg16(pattern_gen_pkg::OFS_BAR_SIZE_HI, barLen);
    pg16(pattern_gen_pkg::OFS_ACT_LINES_HI, act);
    pg16(pattern_gen_pkg::OFS_TOT_LINES_HI, tot);
    pg16(pattern_gen_pkg::OFS_LINE_PD_HI, period);
    pg(pattern_gen_pkg::OFS_VBP, 8'(vbp));
    pg(pattern_gen_pkg::OFS_VFP, 8'(vfp));
    tFs = -1;
    fsSeen = 0;
    repeat (nFr) pushFrame();
    pg(pattern_gen_pkg::OFS_CTL, 8'h01);
    for (n = 0; n < 4000 && fsSeen < nFr; n++) @(negedge clk_sys);
    pg(pattern_gen_pkg::OFS_CTL, 8'h00);
    for (n = 0; n < 4000 && frameActive !== 1'b0; n++) @(negedge clk_sys);
    check("frame idle", 1'b0, frameActive);
    check("beats left", 0, expQ.size());
  endtask : runCase

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(13));
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    wr(pattern_gen_pkg::ADDR_PAGE, pattern_gen_pkg::PAGE_PATGEN);
    foreach (defOfs[i]) begin
      rdp(defOfs[i]);
      check("reset value", defVal[i], got);
    end
    for (int i = 0; i < 16; i++) begin
      pat[i] = 8'($urandom);
      pg(8'(pattern_gen_pkg::OFS_PATTERN_BASE + i), pat[i]);
    end
    for (int i = 0; i < 16; i++) begin
      rdp(8'(pattern_gen_pkg::OFS_PATTERN_BASE + i));
      check("pattern byte", pat[i], got);
    end
    wr(pattern_gen_pkg::ADDR_PAGE, 8'h01);
    pg(pattern_gen_pkg::OFS_CSI_ID, 8'h55);
    rd(pattern_gen_pkg::ADDR_DATA);
    check("other page", 8'h00, got);
    wr(pattern_gen_pkg::ADDR_PAGE, pattern_gen_pkg::PAGE_PATGEN);
    rdp(pattern_gen_pkg::OFS_CSI_ID);
    check("page guard", 8'h24, got);
    rd(8'h10);
    check("unmapped", 8'h00, got);
    runCase(3, 1'b0, 2, 8'h03);
    slow = 1'b1;
    for (int c = 0; c < 3; c++) runCase(c, 1'b0, 1, 8'h03);
    slow = 1'b0;
    runCase(2, 1'b1, 1, 8'h05);
    slow = 1'b1;
    runCase(3, 1'b1, 1, 8'h00);
    results();
  end

  // a hang ends the run through the same verdict
  initial begin
    repeat (40000) @(posedge clk_sys);
    fails++;
    results();
  end
endmodule : csi2_pattern_gen_tb
`default_nettype wire

// ===== csi_tx_sink.sv
// far-side model of the csi-2 transmitter taking pattern beats
// assumes a beat moves on a clk_sys rising edge with txValid and txReady high
`timescale 1ns/1ps
`default_nettype none
module csi_tx_sink (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic slow,
  output logic txReady
);
  // ****************************************
  // ready pacing
  // ****************************************
  // random stalls stretch lines, so line timing is only judged when prompt
  always @(negedge clk_sys) begin
    if (!rst_n) begin
      txReady <= 1'b0;
    end else begin
      txReady <= slow ? 1'($urandom_range(1)) : 1'b1;
    end
  end
endmodule : csi_tx_sink
`default_nettype wire

// ===== pattern_byte_store.sv
// sixteen byte registers holding the fixed pattern block
// assumes writes come from the indirect register decode of the generator
`timescale 1ns/1ps
`default_nettype none
module pattern_byte_store #(
  parameter int DEPTH = pattern_gen_pkg::PATTERN_MAX_BYTES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wrEn,
  input wire logic [$clog2(DEPTH)-1:0] wrIndex,
  input wire logic [7:0] wrData,
  output logic [DEPTH-1:0][7:0] bytes
);
  localparam int AW = $clog2(DEPTH);

  // ****************************************
  // one register per byte position
  // ****************************************
  for (genvar i = 0; i < DEPTH; i++) begin : g_byte
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        bytes[i] <= pattern_gen_pkg::RST_PATTERN_BYTE;
      end else if (wrEn && wrIndex == AW'(i)) begin
        bytes[i] <= wrData;
      end
    end
  end
endmodule : pattern_byte_store
`default_nettype wire

// ===== pattern_gen_pkg.sv
// constants, state codes and beat layout for the test pattern generator
// assumes one clock domain shared with the csi-2 transmitter
package pattern_gen_pkg;

  // ****************************************
  // register addresses and page offsets
  // ****************************************
  localparam logic [7:0] ADDR_PAGE = 8'hB0;
  localparam logic [7:0] ADDR_OFFSET = 8'hB1;
  localparam logic [7:0] ADDR_DATA = 8'hB2;
  localparam logic [7:0] PAGE_PATGEN = 8'h00;
  localparam logic [7:0] OFS_CTL = 8'h01;
  localparam logic [7:0] OFS_CFG = 8'h02;
  localparam logic [7:0] OFS_CSI_ID = 8'h03;
  localparam logic [7:0] OFS_LINE_SIZE_HI = 8'h04;
  localparam logic [7:0] OFS_LINE_SIZE_LO = 8'h05;
  localparam logic [7:0] OFS_BAR_SIZE_HI = 8'h06;
  localparam logic [7:0] OFS_BAR_SIZE_LO = 8'h07;
  localparam logic [7:0] OFS_ACT_LINES_HI = 8'h08;
  localparam logic [7:0] OFS_ACT_LINES_LO = 8'h09;
  localparam logic [7:0] OFS_TOT_LINES_HI = 8'h0A;
  localparam logic [7:0] OFS_TOT_LINES_LO = 8'h0B;
  localparam logic [7:0] OFS_LINE_PD_HI = 8'h0C;
  localparam logic [7:0] OFS_LINE_PD_LO = 8'h0D;
  localparam logic [7:0] OFS_VBP = 8'h0E;
  localparam logic [7:0] OFS_VFP = 8'h0F;
  localparam logic [7:0] OFS_CFG_END = 8'h10;
  localparam logic [7:0] OFS_BLOCK_LEN = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h11;
  localparam logic [7:0] OFS_PATTERN_BASE = 8'h20;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTL_ENABLE_BIT = 0;
  localparam int CFG_FIXED_BIT = 7;
  localparam int CFG_BARS_LSB = 4;
  localparam int ID_VC_LSB = 6;

  // ****************************************
  // reset values
  // ****************************************
  // byte i of the low page sits at bits [8*i +: 8]
  localparam logic [127:0] RST_CFG_BYTES = 128'h00000000_00000000_00000000_24300000;
  localparam logic [7:0] RST_BLOCK_LEN = 8'h03;
  localparam logic [7:0] RST_PATTERN_BYTE = 8'h00;

  // ****************************************
  // pattern and packet constants
  // ****************************************
  localparam logic [63:0] REF_BAR_BYTES = 64'h800FCC557FF033AA;
  localparam logic [5:0] DT_FRAME_START = 6'h00;
  localparam logic [5:0] DT_FRAME_END = 6'h01;
  localparam int PATTERN_MAX_BYTES = 16;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int LINE_UNIT_NS = 10;
  localparam int LINE_UNIT_CYCLES = (LINE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_FS, ST_FE, ST_HDR, ST_DATA} gen_state_t;

  typedef struct packed {
    logic header;
    logic [7:0] dataId;
    logic [15:0] wordCount;
    logic [7:0] payload;
    logic last;
  } csi_beat_t;

endpackage : pattern_gen_pkg
